/* verilog/synth_b_pkg.sv */
// Purpose: Shared constants for the second synthesizer control bank.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Register indices, byte addresses, fields, reset values, timing counts.
`default_nettype none

package synth_b_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    // Byte address is four times the register index
    localparam logic [7:0] DIV_SYNC_PWR_IDX = 8'h47;
    localparam logic [7:0] SEC_PUMP_IDX     = 8'h48;
    // Status index is this block's own choice, clear of the control words
    localparam logic [7:0] STATUS_IDX       = 8'hff;
    localparam logic [9:0] DIV_SYNC_PWR_OFS = {DIV_SYNC_PWR_IDX, 2'b00};
    localparam logic [9:0] SEC_PUMP_OFS     = {SEC_PUMP_IDX, 2'b00};
    localparam logic [9:0] STATUS_OFS       = {STATUS_IDX, 2'b00};

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int         POST_DIV_LSB     = 2;
    localparam int         RESYNC_BIT       = 1;
    localparam int         POWER_DOWN_BIT   = 0;
    localparam int         SPARE_BIT        = 5;
    localparam int         DOUBLER_BIT      = 4;
    localparam logic [2:0] POST_DIV_RESET   = 3'h7;
    localparam logic       RESYNC_RESET     = 1'b1;
    localparam logic       POWER_DOWN_RESET = 1'b0;
    localparam logic       DOUBLER_RESET    = 1'b1;
    localparam logic [3:0] PUMP_GAIN_RESET  = 4'h8;

    // ----------------------------------------------------------------
    // Decode constants
    // ----------------------------------------------------------------
    localparam logic [2:0] POST_DIV_MIN_CODE = 3'h2;
    localparam logic [3:0] POST_DIV_MIN_RATIO = 4'h2;
    localparam logic [3:0] PUMP_MAX_STEP_CODE = 4'h7;
    localparam logic [3:0] PUMP_HIGH_CODE     = 4'h8;
    localparam logic [6:0] PUMP_HIGH_TENTHS   = 7'h40;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int CAL_TIME_NS   = 100000;
    localparam int CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {CAL_OFF, CAL_RUN, CAL_LOCKED} cal_state_t;
endpackage : synth_b_pkg

`default_nettype wire

/* verilog/pin_filter.sv */
// Purpose: Bring an outside level into the clk domain and debounce it.
// Assumes: Input is asynchronous to clk.
// Notes:   Output moves only when the second and third stages agree.
`default_nettype none

module pin_filter (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pinIn,
    output var  logic level_ff
);
    logic stage1_ff;
    logic stage2_ff;
    logic stage3_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
            stage3_ff <= 1'b0;
        end else begin
            stage1_ff <= pinIn;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_ff <= 1'b0;
        end else if (stage2_ff == stage3_ff) begin
            level_ff <= stage3_ff;
        end
    end
endmodule : pin_filter

`default_nettype wire

/* verilog/synth_b_ctrl.sv */
// Purpose: Control bank for the second synthesizer, reached over APB.
// Assumes: Single 10 MHz clock, asynchronous active-high reset.
// Notes:   Decoded analog controls are registered; calibration is timed.
//
// The APB register port is this design's own decision.
`default_nettype none

module synth_b_ctrl
    import synth_b_pkg::*;
#(
    parameter int CalCycles = CAL_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        syncPin,
    output var  logic [3:0]  postDivRatio,
    output var  logic        resyncPulse,
    output var  logic        synthEnable,
    output var  logic        calReset,
    output var  logic        calRunning,
    output var  logic        doublerEnable,
    output var  logic [6:0]  pumpTenthsMa
);
    // ----------------------------------------------------------------
    // Register fields
    // ----------------------------------------------------------------
    logic [2:0]  synth_b_post_divider_select_ff;
    logic        synth_b_resync_enable_ff;
    logic        synth_b_power_down_ff;
    logic        spareBit_ff;
    logic        secondary_reference_doubler_enable_ff;
    logic [3:0]  synth_b_charge_pump_gain_ff;
    cal_state_t  calState_ff;
    logic [15:0] calCount_ff;
    logic        syncLevel_ff;
    logic        syncPrev_ff;
    logic        syncRise;
    logic        wrEn;
    logic        setupPhase;
    logic        mapped;
    logic [31:0] nxt_prdata;

    assign setupPhase = psel && !penable;
    assign wrEn       = psel && penable && pready && pwrite;
    assign mapped     = (paddr == DIV_SYNC_PWR_OFS) || (paddr == SEC_PUMP_OFS)
                        || (paddr == STATUS_OFS);

    // ----------------------------------------------------------------
    // APB slave, one wait-free access phase
    // ----------------------------------------------------------------
    always_comb begin
        nxt_prdata = 32'h0;
        case (paddr)
            DIV_SYNC_PWR_OFS: nxt_prdata = {27'h0, synth_b_post_divider_select_ff,
                                            synth_b_resync_enable_ff,
                                            synth_b_power_down_ff};
            SEC_PUMP_OFS:     nxt_prdata = {26'h0, spareBit_ff,
                                            secondary_reference_doubler_enable_ff,
                                            synth_b_charge_pump_gain_ff};
            STATUS_OFS:       nxt_prdata = {16'h0, calState_ff, synthEnable, 1'b0,
                                            postDivRatio, 1'b0, pumpTenthsMa};
            default:          nxt_prdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setupPhase;
            pslverr <= setupPhase && !mapped;
            if (setupPhase) begin
                prdata <= pwrite ? 32'h0 : nxt_prdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            synth_b_post_divider_select_ff <= POST_DIV_RESET;
            synth_b_resync_enable_ff       <= RESYNC_RESET;
            synth_b_power_down_ff          <= POWER_DOWN_RESET;
        end else if (wrEn && paddr == DIV_SYNC_PWR_OFS) begin
            synth_b_post_divider_select_ff <= pwdata[POST_DIV_LSB +: 3];
            synth_b_resync_enable_ff       <= pwdata[RESYNC_BIT];
            synth_b_power_down_ff          <= pwdata[POWER_DOWN_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spareBit_ff                           <= 1'b0;
            secondary_reference_doubler_enable_ff <= DOUBLER_RESET;
            synth_b_charge_pump_gain_ff           <= PUMP_GAIN_RESET;
        end else if (wrEn && paddr == SEC_PUMP_OFS) begin
            spareBit_ff                           <= pwdata[SPARE_BIT];
            secondary_reference_doubler_enable_ff <= pwdata[DOUBLER_BIT];
            synth_b_charge_pump_gain_ff           <= pwdata[3:0];
        end
    end

    // ----------------------------------------------------------------
    // Analog control decode
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            postDivRatio  <= 4'h0;
            doublerEnable <= 1'b0;
            pumpTenthsMa  <= 7'h0;
        end else begin
            if (synth_b_post_divider_select_ff < POST_DIV_MIN_CODE) begin
                postDivRatio <= POST_DIV_MIN_RATIO;
            end else begin
                postDivRatio <= {1'b0, synth_b_post_divider_select_ff} + 4'h1;
            end
            doublerEnable <= secondary_reference_doubler_enable_ff;
            if (synth_b_charge_pump_gain_ff == PUMP_HIGH_CODE) begin
                pumpTenthsMa <= PUMP_HIGH_TENTHS;
            end else if (synth_b_charge_pump_gain_ff <= PUMP_MAX_STEP_CODE) begin
                pumpTenthsMa <= {1'b0, synth_b_charge_pump_gain_ff, 2'b00};
            end else begin
                pumpTenthsMa <= 7'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sync event
    // ----------------------------------------------------------------
    pin_filter i_pin_filter (
        .clk      (clk),
        .rst      (rst),
        .pinIn    (syncPin),
        .level_ff (syncLevel_ff)
    );

    assign syncRise = syncLevel_ff && !syncPrev_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncPrev_ff <= 1'b0;
            resyncPulse <= 1'b0;
        end else begin
            syncPrev_ff <= syncLevel_ff;
            resyncPulse <= syncRise && synth_b_resync_enable_ff;
        end
    end

    // ----------------------------------------------------------------
    // Power and calibration sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            calState_ff <= CAL_RUN;
            calCount_ff <= 16'h0;
        end else begin
            case (calState_ff)
                CAL_OFF: begin
                    calCount_ff <= 16'h0;
                    if (!synth_b_power_down_ff) begin
                        calState_ff <= CAL_RUN;
                    end
                end
                CAL_RUN: begin
                    calCount_ff <= calCount_ff + 16'h1;
                    if (synth_b_power_down_ff) begin
                        calState_ff <= CAL_OFF;
                    end else if (calCount_ff == 16'(CalCycles - 1)) begin
                        calState_ff <= CAL_LOCKED;
                    end
                end
                CAL_LOCKED: begin
                    if (synth_b_power_down_ff) begin
                        calState_ff <= CAL_OFF;
                    end
                end
                default: calState_ff <= CAL_OFF;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            synthEnable <= 1'b0;
            calReset    <= 1'b1;
            calRunning  <= 1'b0;
        end else begin
            // disable and hold calibration in reset
            synthEnable <= !synth_b_power_down_ff;
            calReset    <= synth_b_power_down_ff;
            calRunning  <= (calState_ff == CAL_RUN) && !synth_b_power_down_ff;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence powerDownSeen;
        $rose(synth_b_power_down_ff);
    endsequence

    sequence powerUpSeen;
        $fell(synth_b_power_down_ff);
    endsequence

    div_low_a: assert property (
        synth_b_post_divider_select_ff < POST_DIV_MIN_CODE |=> postDivRatio == 4'h2)
        else $error("low post-divider code not decoded as 2");
    div_high_a: assert property (
        synth_b_post_divider_select_ff >= POST_DIV_MIN_CODE
        |=> postDivRatio == {1'b0, $past(synth_b_post_divider_select_ff)} + 4'h1)
        else $error("post-divider ratio not code plus one");
    resync_gate_a: assert property (
        ##1 resyncPulse == ($past(syncRise) && $past(synth_b_resync_enable_ff)))
        else $error("resync pulse does not follow enabled sync event");
    cal_start_a: assert property (
        $rose(calRunning) |-> !$past(synth_b_power_down_ff))
        else $error("calibration started while powered down");
    power_down_a: assert property (
        powerDownSeen |=> !synthEnable && calReset && !calRunning [*2])
        else $error("power-down did not disable synthesizer");
    cal_restart_a: assert property (
        powerUpSeen |-> ##[1:2] (calRunning && synthEnable && !calReset))
        else $error("calibration not restarted on power-up");
    doubler_a: assert property (
        $changed(secondary_reference_doubler_enable_ff)
        |=> doublerEnable == $past(secondary_reference_doubler_enable_ff))
        else $error("doubler control does not follow its bit");
    pump_a: assert property (
        synth_b_charge_pump_gain_ff == 4'h8 |=> pumpTenthsMa == 7'h40)
        else $error("pump code 8 not decoded as 6.4 mA");
    pump_step_a: assert property (
        synth_b_charge_pump_gain_ff == 4'h3 |=> pumpTenthsMa == 7'hc)
        else $error("pump code 3 not decoded as 1.2 mA");
endmodule : synth_b_ctrl

`default_nettype wire

/* sim/synth_b_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the second synthesizer control bank.
// Assumes: APB slave answers one cycle after setup; calibration shortened to 20 cycles.
// Notes:   Inputs change by non-blocking assignment at rising edges.
`default_nettype none

module synth_b_ctrl_tb_top
    import synth_b_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int Cal = 20;

    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        syncPin;
    logic [3:0]  postDivRatio;
    logic        resyncPulse;
    logic        synthEnable;
    logic        calReset;
    logic        calRunning;
    logic        doublerEnable;
    logic [6:0]  pumpTenthsMa;
    logic [31:0] rdata;
    logic        err;
    int          error_cnt;
    int          compares;
    int          cycles;

    synth_b_ctrl #(.CalCycles(Cal)) i_synth_b_ctrl (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .syncPin(syncPin), .postDivRatio(postDivRatio),
        .resyncPulse(resyncPulse), .synthEnable(synthEnable), .calReset(calReset),
        .calRunning(calRunning), .doublerEnable(doublerEnable),
        .pumpTenthsMa(pumpTenthsMa)
    );

    // ----------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Values are sampled at the edge, before the design's updates land
    task automatic apb(input logic wr, input logic [9:0] addr, input logic [31:0] data);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic sync_event(input logic [31:0] exp);
        int hits;
        hits = 0;
        @(posedge clk);
        syncPin <= 1'b1;
        repeat (12) begin
            @(posedge clk);
            if (resyncPulse === 1'b1) hits++;
        end
        syncPin <= 1'b0;
        repeat (12) @(posedge clk);
        check("resync pulses", hits, exp);
    endtask : sync_event

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        repeat (2) @(posedge clk);
        check("reset ratio", postDivRatio, 32'h8);
        check("reset pump", pumpTenthsMa, 32'h40);
        check("reset doubler", doublerEnable, 32'h1);
        check("reset enable", synthEnable, 32'h1);
        check("reset cal", calRunning, 32'h1);
        apb(1'b0, DIV_SYNC_PWR_OFS, 32'h0);
        check("div reg reset", rdata, 32'h1e);
        apb(1'b0, SEC_PUMP_OFS, 32'h0);
        check("pump reg reset", rdata, 32'h18);
    endtask : t_reset

    task automatic t_divider();
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, DIV_SYNC_PWR_OFS, 32'(c << 2) | 32'h2);
            repeat (3) @(posedge clk);
            check("ratio", postDivRatio, (c < 2) ? 32'h2 : 32'(c + 1));
            apb(1'b0, DIV_SYNC_PWR_OFS, 32'h0);
            check("div reg", rdata, 32'(c << 2) | 32'h2);
        end
    endtask : t_divider

    task automatic t_pump();
        logic [31:0] exp;
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, SEC_PUMP_OFS, 32'((c % 2) << 4) | 32'(c));
            repeat (3) @(posedge clk);
            exp = (c >= 1 && c <= 7) ? 32'(4 * c) : (c == 8) ? 32'h40 : 32'h0;
            check("pump", pumpTenthsMa, exp);
            check("doubler", doublerEnable, 32'(c % 2));
        end
    endtask : t_pump

    task automatic t_power();
        int n;
        apb(1'b1, DIV_SYNC_PWR_OFS, 32'h1f);
        repeat (3) @(posedge clk);
        check("pdn enable", synthEnable, 32'h0);
        check("pdn cal reset", calReset, 32'h1);
        check("pdn cal run", calRunning, 32'h0);
        apb(1'b1, DIV_SYNC_PWR_OFS, 32'h1e);
        n = 0;
        while (calRunning !== 1'b1 && n < 6) begin
            @(posedge clk);
            n++;
        end
        check("restart cal", calRunning, 32'h1);
        n = 0;
        while (calRunning === 1'b1 && n < Cal + 50) begin
            @(posedge clk);
            n++;
        end
        check("cal length", n, Cal);
        check("restart enable", synthEnable, 32'h1);
        check("restart cal reset", calReset, 32'h0);
    endtask : t_power

    task automatic t_resync();
        apb(1'b1, DIV_SYNC_PWR_OFS, 32'h1e);
        sync_event(32'h1);
        apb(1'b1, DIV_SYNC_PWR_OFS, 32'h1c);
        sync_event(32'h0);
    endtask : t_resync

    task automatic t_bus();
        apb(1'b0, 10'h100, 32'h0);
        check("unmapped err", err, 32'h1);
        check("unmapped data", rdata, 32'h0);
        apb(1'b1, STATUS_OFS, 32'hffff);
        check("status write err", err, 32'h0);
        apb(1'b0, STATUS_OFS, 32'h0);
        check("status ratio enable", rdata[13:8], 32'h28);
        check("status word", rdata, 32'ha800);
    endtask : t_bus

    initial begin
        rst       = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 10'h000;
        pwdata    = 32'h0;
        syncPin   = 1'b0;
        error_cnt = 0;
        compares  = 0;
        cycles    = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_divider();
        t_pump();
        t_power();
        t_resync();
        t_bus();
        end_of_test();
    end
endmodule : synth_b_ctrl_tb_top

`default_nettype wire
